// [csd_decoder.sv]
// Purpose: Chip-select area decoder with Wishbone register file
// Assumes: Classic Wishbone, 32-bit data, byte addresses, synchronous reset
// Notes:   Chip selects and cycle settings are registered, one cycle after address
//
// Contract
// - Start register gives address bits 23..16; lower sixteen bits are zero.
// - Reset sets every start and mask register to all ones.
// - Only address bits with a zero mask bit, and the bits above an area's mask field, take part in compare.
// - Area 0 masks bits 20..16, 15, shared 14..9, and 8.
// - Area 1 masks bits 21..16, shared 15..9, and bit 8.
// - Areas 2 and 3 mask bits 22 down to 15, one each.
// - Areas 0, 1 and 3 are disabled after reset.
// - Area 2 enabled after reset, fixed range 002000 to FDFFFF.
// - Unmatched addresses use the default area bus width and waits.
// - Among several matching areas the lowest number wins.
// - Every bus cycle compares address; match asserts select and settings.
`timescale 1ns/10ps
module csd_decoder
	import csd_pkg::*;
#(
	parameter int ADR_W = 12
)(
	input  wire logic                  ref_clk_i,     // System clock, 40 MHz
	input  wire logic                  sys_rst_i,     // Synchronous reset, high
	input  wire logic [ADR_W-1:0]      wb_adr_i,      // Wishbone byte address
	input  wire logic [31:0]           wb_dat_i,      // Write data
	output logic      [31:0]           wb_dat_o,      // Read data
	input  wire logic                  wb_we_i,       // Write enable
	input  wire logic [3:0]            wb_sel_i,      // Byte lanes
	input  wire logic                  wb_cyc_i,      // Cycle
	input  wire logic                  wb_stb_i,      // Strobe
	output logic                       wb_ack_o,      // Acknowledge
	input  wire logic [CSD_ADDR_W-1:0] bus_addr_i,    // CPU bus address
	input  wire logic                  bus_cycle_i,   // CPU bus cycle active
	output logic      [3:0]            area_sel_n_o,  // Chip selects, low active
	output csd_pkg::csd_cycle_s        cycle_cfg_o    // Settings of this cycle
);
	import csd_pkg::*;

	// Parameter check
	generate
		if (ADR_W < 10 || ADR_W > 32)
		begin : g_chk
			$error("csd_decoder ADR_W must lie between 10 and 32");
		end
	endgenerate

	// Register state
	logic [7:0]  start_q [CSD_AREAS];
	logic [7:0]  mask_q  [CSD_AREAS];
	csd_ctrl_s   ctrl_q  [CSD_AREAS];
	csd_ctrl_s   dflt_q;
	logic [7:0]  next_start [CSD_AREAS];
	logic [7:0]  next_mask  [CSD_AREAS];
	csd_ctrl_s   next_ctrl  [CSD_AREAS];
	csd_ctrl_s   next_dflt;

	// Bus slave state
	logic        ack_q;
	logic        next_ack;
	logic [31:0] rdata_q;
	logic [31:0] next_rdata;

	// Decode state
	csd_cycle_s  cycle_q;
	csd_cycle_s  next_cycle;

	// Access decode
	logic        req;
	logic        wr_lane0;
	logic        idx_ok;
	logic [7:0]  idx;

	// Matching
	logic [CSD_ADDR_W-1:0] ignore [CSD_AREAS];
	logic [CSD_AREAS-1:0]  hit_cmp;
	logic [CSD_AREAS-1:0]  hit;
	logic [CSD_AREAS-1:0]  win;
	logic                  any_hit;
	logic                  area2_fixed_hit;

	// Expand an area's mask register to one ignore bit per address bit
	function automatic logic [CSD_ADDR_W-1:0] ignore_bits(input int area, input logic [7:0] m);
		logic [CSD_ADDR_W-1:0] r;
		r = '0;
		unique case (area)
			0:
			begin
				r[CSD_A0_TOP -: 5]       = m[7:3];
				r[CSD_A23_LSB]           = m[2];
				r[14:9]                  = {6{m[1]}};
				r[CSD_FINE_BIT]          = m[0];
				r[CSD_FINE_BIT-1:0]      = '1;
			end
			1:
			begin
				r[CSD_A1_TOP -: 6]       = m[7:2];
				r[CSD_A23_LSB:9]         = {7{m[1]}};
				r[CSD_FINE_BIT]          = m[0];
				r[CSD_FINE_BIT-1:0]      = '1;
			end
			default:
			begin
				r[CSD_A23_TOP:CSD_A23_LSB] = m;
				r[CSD_A23_LSB-1:0]         = '1;
			end
		endcase
		return r;
	endfunction

	// Wishbone request decode
	assign req      = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_lane0 = wb_cyc_i && wb_stb_i && ack_q && wb_we_i && wb_sel_i[0]; // Lands with ack
	assign idx      = wb_adr_i[9:2];
	assign idx_ok   = (ADR_W == 10) ? 1'b1 : (wb_adr_i[ADR_W-1:ADR_W-1] == 1'b0
	                  && (wb_adr_i >> 10) == '0);

	// Next register values from writes
	always_comb
	begin
		for (int a = 0; a < CSD_AREAS; a++)
		begin
			next_start[a] = start_q[a];
			next_mask[a]  = mask_q[a];
			next_ctrl[a]  = ctrl_q[a];
		end
		next_dflt = dflt_q;
		if (wr_lane0 && idx_ok)
		begin
			unique case (idx)
				CSD_IDX_AREA0_START: next_start[0] = wb_dat_i[7:0];
				CSD_IDX_AREA1_START: next_start[1] = wb_dat_i[7:0];
				CSD_IDX_AREA2_START: next_start[2] = wb_dat_i[7:0];
				CSD_IDX_AREA3_START: next_start[3] = wb_dat_i[7:0];
				CSD_IDX_AREA0_MASK:  next_mask[0]  = wb_dat_i[7:0];
				CSD_IDX_AREA1_MASK:  next_mask[1]  = wb_dat_i[7:0];
				CSD_IDX_AREA2_MASK:  next_mask[2]  = wb_dat_i[7:0];
				CSD_IDX_AREA3_MASK:  next_mask[3]  = wb_dat_i[7:0];
				CSD_IDX_AREA0_CTRL:  next_ctrl[0]  = wb_dat_i[7:0] & ~(8'h01 << CSD_MAP_BIT);
				CSD_IDX_AREA1_CTRL:  next_ctrl[1]  = wb_dat_i[7:0] & ~(8'h01 << CSD_MAP_BIT);
				CSD_IDX_AREA2_CTRL:  next_ctrl[2]  = wb_dat_i[7:0];
				CSD_IDX_AREA3_CTRL:  next_ctrl[3]  = wb_dat_i[7:0] & ~(8'h01 << CSD_MAP_BIT);
				CSD_IDX_DFLT_CTRL:   next_dflt     = wb_dat_i[7:0] & 8'h3F;
				default:             next_dflt     = dflt_q;
			endcase
		end
	end

	// Register file storage
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			for (int a = 0; a < CSD_AREAS; a++)
			begin
				start_q[a] <= CSD_RST_START;
				mask_q[a]  <= CSD_RST_MASK;
				ctrl_q[a]  <= CSD_RST_CTRL;
			end
			ctrl_q[2] <= CSD_RST_CTRL2;
			dflt_q    <= CSD_RST_CTRL;
		end
		else
		begin
			for (int a = 0; a < CSD_AREAS; a++)
			begin
				start_q[a] <= next_start[a];
				mask_q[a]  <= next_mask[a];
				ctrl_q[a]  <= next_ctrl[a];
			end
			dflt_q <= next_dflt;
		end
	end

	// Read data and acknowledge, one wait cycle per access
	always_comb
	begin
		next_ack   = req;
		next_rdata = 32'h0000_0000;
		if (req && !wb_we_i && idx_ok)
		begin
			unique case (idx)
				CSD_IDX_AREA0_START: next_rdata[7:0] = start_q[0];
				CSD_IDX_AREA1_START: next_rdata[7:0] = start_q[1];
				CSD_IDX_AREA2_START: next_rdata[7:0] = start_q[2];
				CSD_IDX_AREA3_START: next_rdata[7:0] = start_q[3];
				CSD_IDX_AREA0_MASK:  next_rdata[7:0] = mask_q[0];
				CSD_IDX_AREA1_MASK:  next_rdata[7:0] = mask_q[1];
				CSD_IDX_AREA2_MASK:  next_rdata[7:0] = mask_q[2];
				CSD_IDX_AREA3_MASK:  next_rdata[7:0] = mask_q[3];
				CSD_IDX_AREA0_CTRL:  next_rdata[7:0] = ctrl_q[0];
				CSD_IDX_AREA1_CTRL:  next_rdata[7:0] = ctrl_q[1];
				CSD_IDX_AREA2_CTRL:  next_rdata[7:0] = ctrl_q[2];
				CSD_IDX_AREA3_CTRL:  next_rdata[7:0] = ctrl_q[3];
				CSD_IDX_DFLT_CTRL:   next_rdata[7:0] = dflt_q;
				CSD_IDX_STATUS:      next_rdata[7:0] = {3'b000, cycle_q.default_hit,
				                                        ~cycle_q.sel_n};
				default:             next_rdata      = 32'h0000_0000;
			endcase
		end
	end

	// Bus slave registers
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q   <= next_ack;
			rdata_q <= next_rdata;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdata_q;

	// Per-area comparators
	generate
		for (genvar g = 0; g < CSD_AREAS; g++)
		begin : g_area
			assign ignore[g] = ignore_bits(g, mask_q[g]);
			csd_area_match u_match (
				.addr_i   (bus_addr_i),
				.start_i  (start_q[g]),
				.ignore_i (ignore[g]),
				.enable_i (ctrl_q[g].enable),
				.hit_o    (hit_cmp[g])
			);
		end
	endgenerate

	// Area two fixed window when map mode is clear
	assign area2_fixed_hit = ctrl_q[2].enable
	                         && (bus_addr_i >= CSD_AREA2_FIX_LO)
	                         && (bus_addr_i <= CSD_AREA2_FIX_HI);

	// Hits per area, area two chooses its map
	always_comb
	begin
		hit    = hit_cmp;
		hit[2] = ctrl_q[2].map_mode ? hit_cmp[2] : area2_fixed_hit;
	end

	// Priority resolution
	csd_prio_sel #(
		.N (CSD_AREAS)
	) u_prio (
		.hit_i    (hit),
		.onehot_o (win),
		.any_o    (any_hit)
	);

	// Settings of the running cycle
	always_comb
	begin
		next_cycle.sel_n       = 4'hF;
		next_cycle.default_hit = 1'b0;
		next_cycle.waveform    = 2'b00;
		next_cycle.narrow      = 1'b0;
		next_cycle.waits       = 3'b000;
		if (bus_cycle_i)
		begin
			if (any_hit)
			begin
				next_cycle.sel_n = ~win;
				for (int a = 0; a < CSD_AREAS; a++)
				begin
					if (win[a])
					begin
						next_cycle.waveform = ctrl_q[a].waveform;
						next_cycle.narrow   = ctrl_q[a].narrow;
						next_cycle.waits    = ctrl_q[a].waits;
					end
				end
			end
			else
			begin
				next_cycle.default_hit = 1'b1;
				next_cycle.waveform    = dflt_q.waveform;
				next_cycle.narrow      = dflt_q.narrow;
				next_cycle.waits       = dflt_q.waits;
			end
		end
	end

	// Registered cycle outputs
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			cycle_q <= {4'hF, 7'h00};
		end
		else
		begin
			cycle_q <= next_cycle;
		end
	end

	assign area_sel_n_o = cycle_q.sel_n;
	assign cycle_cfg_o  = cycle_q;
endmodule

// [csd_pkg.sv]
// Purpose: Shared constants, types and helpers of the chip-select area decoder
// Assumes: 24-bit CPU bus address, registers reached over 32-bit Wishbone
// Notes:   Register indexes are word indexes; byte address is four times the index
package csd_pkg;

	// Geometry of the decoder
	localparam int CSD_AREAS     = 4;
	localparam int CSD_ADDR_W    = 24;
	localparam int CSD_REG_W     = 8;
	localparam int CSD_IDX_W     = 8;

	// Register indexes (byte address = index * 4)
	localparam logic [7:0] CSD_IDX_AREA0_CTRL  = 8'hC0;
	localparam logic [7:0] CSD_IDX_AREA1_CTRL  = 8'hC1;
	localparam logic [7:0] CSD_IDX_AREA2_CTRL  = 8'hC2;
	localparam logic [7:0] CSD_IDX_AREA3_CTRL  = 8'hC3;
	localparam logic [7:0] CSD_IDX_DFLT_CTRL   = 8'hC7;
	localparam logic [7:0] CSD_IDX_AREA0_START = 8'hC8;
	localparam logic [7:0] CSD_IDX_AREA0_MASK  = 8'hC9;
	localparam logic [7:0] CSD_IDX_AREA1_START = 8'hCA;
	localparam logic [7:0] CSD_IDX_AREA1_MASK  = 8'hCB;
	localparam logic [7:0] CSD_IDX_AREA2_START = 8'hCC;
	localparam logic [7:0] CSD_IDX_AREA2_MASK  = 8'hCD;
	localparam logic [7:0] CSD_IDX_AREA3_START = 8'hCE;
	localparam logic [7:0] CSD_IDX_AREA3_MASK  = 8'hCF;
	localparam logic [7:0] CSD_IDX_STATUS      = 8'hD0;

	// Reset values
	localparam logic [7:0] CSD_RST_START = 8'hFF;
	localparam logic [7:0] CSD_RST_MASK  = 8'hFF;
	localparam logic [7:0] CSD_RST_CTRL  = 8'h00;
	localparam logic [7:0] CSD_RST_CTRL2 = 8'h80;

	// Field positions of the area masks
	localparam int CSD_START_LSB = 16;
	localparam int CSD_FINE_BIT  = 8;
	localparam int CSD_A0_TOP    = 20;
	localparam int CSD_A1_TOP    = 21;
	localparam int CSD_A23_TOP   = 22;
	localparam int CSD_A23_LSB   = 15;
	localparam int CSD_MAP_BIT   = 6;

	// Fixed window of area two in its fixed map mode
	localparam logic [23:0] CSD_AREA2_FIX_LO = 24'h002000;
	localparam logic [23:0] CSD_AREA2_FIX_HI = 24'hFDFFFF;

	// Per-area control register layout
	typedef struct packed {
		logic       enable;
		logic       map_mode;
		logic [1:0] waveform;
		logic       narrow;
		logic [2:0] waits;
	} csd_ctrl_s;

	// Settings that steer the running bus cycle
	typedef struct packed {
		logic [3:0] sel_n;
		logic       default_hit;
		logic [1:0] waveform;
		logic       narrow;
		logic [2:0] waits;
	} csd_cycle_s;

endpackage

// [csd_area_match.sv]
// Purpose: Compares one bus address with one area's start and mask
// Assumes: Ignore mask already expanded to full address width
// Notes:   Purely combinational, one instance per area
`timescale 1ns/10ps
module csd_area_match
	import csd_pkg::*;
(
	input  wire logic [CSD_ADDR_W-1:0] addr_i,    // Bus address
	input  wire logic [7:0]            start_i,   // Start bits 23..16
	input  wire logic [CSD_ADDR_W-1:0] ignore_i,  // One marks a bit left out
	input  wire logic                  enable_i,  // Area enable
	output logic                       hit_o      // Address falls in area
);
	logic [CSD_ADDR_W-1:0] base;

	// Start address, low sixteen bits fixed at zero
	assign base = {start_i, 16'h0000};

	// Masked compare, gated by enable
	assign hit_o = enable_i && (((addr_i ^ base) & ~ignore_i) == '0);
endmodule

// [csd_prio_sel.sv]
// Purpose: Picks the lowest numbered hit among several areas
// Assumes: Bit zero has the highest priority
// Notes:   Combinational; any_o low means no area matched
`timescale 1ns/10ps
module csd_prio_sel #(
	parameter int N = 4
)(
	input  wire logic [N-1:0] hit_i,    // Raw hits
	output logic [N-1:0]      onehot_o, // Winning area
	output logic              any_o     // Some area hit
);
	generate
		if (N < 1)
		begin : g_chk
			$error("csd_prio_sel needs at least one input");
		end
	endgenerate

	// Isolate lowest set bit
	assign onehot_o = hit_i & (~hit_i + N'(1));
	assign any_o    = |hit_i;
endmodule

// [csd_decoder_asserts.sv]
// Purpose: Port assertions of the area decoder
// Assumes: Outputs follow the sampled address by one edge
// Notes:   Reset-state checks end at the first write request
`timescale 1ns/10ps
module csd_decoder_asserts #(
	parameter int ADR_W = 12
)(
	input wire logic             ref_clk_i,    // Clock
	input wire logic             sys_rst_i,    // Reset
	input wire logic [ADR_W-1:0] wb_adr_i,     // Address
	input wire logic [31:0]      wb_dat_i,     // Write data
	input wire logic [31:0]      wb_dat_o,     // Read data
	input wire logic             wb_we_i,      // Write
	input wire logic [3:0]       wb_sel_i,     // Lanes
	input wire logic             wb_cyc_i,     // Cycle
	input wire logic             wb_stb_i,     // Strobe
	input wire logic             wb_ack_o,     // Ack
	input wire logic [23:0]      bus_addr_i,   // Bus address
	input wire logic             bus_cycle_i,  // Bus cycle
	input wire logic [3:0]       area_sel_n_o, // Selects
	input wire csd_pkg::csd_cycle_s cycle_cfg_o // Settings
);
	import csd_pkg::*;
	logic wrote;      // Write seen since reset
	logic next_wrote;
	// Remembers write requests since reset
	always_comb
		next_wrote = wrote | (wb_cyc_i & wb_stb_i & wb_we_i);
	always_ff @(posedge ref_clk_i)
		wrote <= sys_rst_i ? 1'b0 : next_wrote;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	chk_ack_delay: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	chk_rd_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	chk_sel_idle: assert property (!bus_cycle_i |=> cycle_cfg_o == 11'h780)
		else $error("outputs active without bus cycle");
	chk_sel_onehot: assert property ($onehot0(~area_sel_n_o))
		else $error("more than one select low");
	chk_cfg_mirror: assert property (cycle_cfg_o.sel_n == area_sel_n_o)
		else $error("settings selects differ from pins");
	chk_default_flag: assert property (!sys_rst_i && bus_cycle_i |=>
		cycle_cfg_o.default_hit == (area_sel_n_o == 4'hF))
		else $error("default flag wrong");
	chk_reset_quiet: assert property (!next_wrote |=>
		area_sel_n_o[0] && area_sel_n_o[1] && area_sel_n_o[3])
		else $error("area active after reset");
	chk_fix_window: assert property (!sys_rst_i && !next_wrote && bus_cycle_i |=>
		area_sel_n_o[2] == !($past(bus_addr_i) inside {[CSD_AREA2_FIX_LO:CSD_AREA2_FIX_HI]}))
		else $error("area two window wrong");
	cover property (area_sel_n_o == 4'hE);
	cover property (cycle_cfg_o.default_hit);
	cover property (wb_ack_o && wb_we_i);
endmodule

bind csd_decoder csd_decoder_asserts #(.ADR_W(ADR_W)) u_chk (.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .bus_addr_i(bus_addr_i), .bus_cycle_i(bus_cycle_i),
	.area_sel_n_o(area_sel_n_o), .cycle_cfg_o(cycle_cfg_o));

// [csd_mem_model.sv]
// Purpose: Four ROM/SRAM devices behind the selects
// Assumes: Selects low active, read data from the held address
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/10ps
module csd_mem_model (
	input  wire logic        clk_i,   // Clock
	input  wire logic [3:0]  sel_n_i, // Selects
	input  wire logic [23:0] addr_i,  // Address
	output logic      [15:0] data_o   // Data
);
	logic [15:0] last = 16'h5A5A; // Last driven value
	logic [15:0] next_last;
	// Selected device answers with its number and address
	always_comb
	begin
		next_last = last;
		data_o = ~last;
		for (int k = 0; k < 4; k++)
			if (!sel_n_i[k])
				data_o = {k[1:0], addr_i[13:0]};
		if (sel_n_i != 4'hF)
			next_last = data_o;
	end
	always_ff @(posedge clk_i)
		last <= next_last;
endmodule

// [csd_decoder_tb.sv]
// Purpose: Self-checking bench of the area decoder
// Assumes: Bench keeps its own copy of the register file
// Notes:   Random area setups from a fixed seed plus corners
`timescale 1ns/10ps
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %s exp %h got %h", w, e, g); end end
module csd_decoder_tb;
	import csd_pkg::*;
	logic        ref_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [11:0] wb_adr_i = 12'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_we_i = 1'b0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_ack_o;
	logic [23:0] bus_addr_i = 24'h0;
	logic        bus_cycle_i = 1'b0;
	logic [3:0]  area_sel_n_o;
	csd_cycle_s  cycle_cfg_o;
	logic [15:0] mem_dat;
	logic [7:0]  rm [256];
	logic [31:0] rd;
	int          seed = 73327;
	int          failures = 0;
	int          n_compared = 0;
	logic [23:0] corner [5] = '{24'h000000, 24'h001FFF, 24'h002000, 24'hFDFFFF, 24'hFE0000};

	csd_decoder #(.ADR_W(12)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
		.bus_addr_i(bus_addr_i), .bus_cycle_i(bus_cycle_i), .area_sel_n_o(area_sel_n_o),
		.cycle_cfg_o(cycle_cfg_o));
	csd_mem_model u_mem (.clk_i(ref_clk_i), .sel_n_i(area_sel_n_o), .addr_i(bus_addr_i),
		.data_o(mem_dat));

	// Clock of 25 ns
	initial
	begin
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// Ignored address bits of one area
	function automatic logic [23:0] ign_of(int n, logic [7:0] m);
		case (n)
			0: return {3'h0, m[7:3], m[2], {6{m[1]}}, m[0], 8'hFF};
			1: return {2'h0, m[7:2], {7{m[1]}}, m[0], 8'hFF};
			default: return {1'b0, m, 15'h7FFF};
		endcase
	endfunction
	// Does area n claim address a
	function automatic logic hit(int n, logic [23:0] a);
		logic [7:0] c;
		c = rm[8'hC0 + n];
		if (!c[7])
			return 1'b0;
		if (n == 2 && !c[6])
			return a >= 24'h002000 && a <= 24'hFDFFFF;
		return ((a ^ {rm[8'hC8 + 2 * n], 16'h0}) & ~ign_of(n, rm[8'hC9 + 2 * n])) == 24'h0;
	endfunction
	// Expected settings, lowest area first
	function automatic logic [10:0] exp_cfg(logic [23:0] a);
		for (int n = 0; n < 4; n++)
			if (hit(n, a))
				return {~(4'h1 << n), 1'b0, rm[8'hC0 + n][5:0]};
		return {4'hF, 1'b1, rm[8'hC7][5:0]};
	endfunction
	// Expected read of a register index
	function automatic logic [31:0] exp_rd(logic [7:0] i);
		logic [7:0] v;
		v = rm[i];
		if (i inside {8'hC0, 8'hC1, 8'hC3, 8'hC7})
			v[6] = 1'b0;
		if (i == 8'hC7)
			v[7] = 1'b0;
		return {24'h0, v};
	endfunction

	task automatic wrap_up();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Reset for 8 cycles, model back to reset values
	task automatic do_reset();
		sys_rst_i <= 1'b1;
		repeat (8) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		foreach (rm[i])
			rm[i] = (i >= 8'hC8 && i <= 8'hCF) ? 8'hFF : 8'h00;
		rm[8'hC2] = 8'h80;
	endtask
	// One classic Wishbone cycle
	task automatic xfer(logic we, logic [11:0] a, logic [7:0] d, logic s0);
		@(posedge ref_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= {3'h0, s0};
		// Hold the request until ack is seen; only the watchdog ends a hang
		do
		begin
			@(posedge ref_clk_i);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(logic [7:0] i, logic [7:0] d);
		xfer(1'b1, {2'b00, i, 2'b00}, d, 1'b1);
		rm[i] = d;
	endtask
	task automatic rd_chk(logic [11:0] a);
		xfer(1'b0, a, 8'h00, 1'b1);
		`CHK("register", (a[11:10] == 2'b00) ? exp_rd(a[9:2]) : 32'h0, rd)
	endtask
	// Presents one bus address, checks selects a cycle later
	task automatic probe(logic [23:0] a, logic cyc);
		logic [10:0] e;
		@(posedge ref_clk_i);
		bus_addr_i <= a;
		bus_cycle_i <= cyc;
		e = cyc ? exp_cfg(a) : 11'h780;
		@(posedge ref_clk_i);
		#1;
		`CHK("settings", e, cycle_cfg_o)
		`CHK("selects", e[10:7], area_sel_n_o)
		if (e[10:7] != 4'hF)
			`CHK("device", {!e[10] | !e[9], !e[10] | !e[8], a[13:0]}, mem_dat)
	endtask

	// Main sequence
	initial
	begin
		do_reset();
		for (int i = 8'hC0; i <= 8'hCF; i++)
			if (i < 8'hC4 || i > 8'hC6)
				rd_chk({2'b00, 8'(i), 2'b00});
		foreach (corner[k])
			probe(corner[k], 1'b1);
		probe(24'h002000, 1'b0);
		repeat (10) probe(24'($random(seed)), 1'b1);
		wr(8'hC8, 8'h01);
		wr(8'hC9, 8'h07);
		wr(8'hC0, 8'h8B);
		probe(24'h010000, 1'b1);
		probe(24'h01FFFF, 1'b1);
		probe(24'h00FFFF, 1'b1);
		xfer(1'b0, 12'h340, 8'h00, 1'b1);
		`CHK("status", 32'h0000_0004, rd)
		xfer(1'b1, 12'h720, 8'h00, 1'b1);
		xfer(1'b1, 12'h324, 8'h00, 1'b0);
		rd_chk(12'h320);
		rd_chk(12'h324);
		rd_chk(12'h720);
		rd_chk(12'h040);
		wr(8'hC2, 8'h00);
		wr(8'hC9, 8'h00);
		wr(8'hC8, 8'h00);
		wr(8'hC3, 8'h81);
		wr(8'hCE, 8'h00);
		wr(8'hCF, 8'hFF);
		probe(24'h0000FF, 1'b1);
		probe(24'h000100, 1'b1);
		probe(24'h7FFFFF, 1'b1);
		probe(24'h800000, 1'b1);
		repeat (40)
		begin
			for (int i = 8'hC0; i <= 8'hCF; i++)
				if (i < 8'hC4 || i > 8'hC6)
					wr(8'(i), 8'($random(seed)));
			for (int k = 0; k < 4; k++)
				probe({rm[8'hC8 + 2 * k], 16'h0} ^ (24'($random(seed)) >> (8 + 2 * k)), 1'b1);
			rd_chk({2'b00, 5'b11001, 3'($random(seed)), 2'b00});
		end
		do_reset();
		rd_chk(12'h320);
		probe(24'h010000, 1'b1);
		wr(8'hC8, 8'h02);
		wr(8'hC9, 8'h0F);
		wr(8'hC0, 8'h80);
		probe(24'h03FFFF, 1'b1);
		probe(24'h01FFFF, 1'b1);
		wrap_up();
	end

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge ref_clk_i);
		failures++;
		wrap_up();
	end
endmodule
